//--- core/sfpm_pkg.sv
// Shared constants and state codes for the serial flash power-mode controller.
`default_nettype none

package sfpm_pkg;

  // ****************************************************************
  // Reference clock and time conversion
  // ****************************************************************
  localparam int REF_PERIOD_NS = 25;

  // Entry and release delays have no printed figure, so these are plain defaults.
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int EARLY_WAKE_NS = 3000;
  localparam int FULL_WAKE_NS = 30000;

  // Write inhibit after power-on lies between 1 and 10 ms; the device keeps at least the minimum.
  localparam int POWERUP_INHIBIT_MIN_US = 1;
  localparam int POWERUP_INHIBIT_MIN_MS = 1;
  localparam int POWERUP_INHIBIT_MAX_MS = 10;
  localparam int POWERUP_SELECT_DELAY_US = 30;

  // Longest delays round down, least delays round up, none below one cycle.
  localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_NS / REF_PERIOD_NS) < 1 ? 1 : (SLEEP_ENTRY_NS / REF_PERIOD_NS);
  localparam int EARLY_WAKE_CYCLES = (EARLY_WAKE_NS / REF_PERIOD_NS) < 1 ? 1 : (EARLY_WAKE_NS / REF_PERIOD_NS);
  localparam int FULL_WAKE_CYCLES = (FULL_WAKE_NS / REF_PERIOD_NS) < 1 ? 1 : (FULL_WAKE_NS / REF_PERIOD_NS);
  localparam int POWERUP_INHIBIT_CYCLES =
    (POWERUP_INHIBIT_MIN_MS * 1000000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam logic [5:0] OPCODE_LAST_BIT = 6'h07;
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] SIG_FIRST_CNT = 6'h20;
  localparam logic [5:0] SIG_LAST_CNT = 6'h27;
  localparam logic [7:0] SLEEP_OPCODE_DEFAULT = 8'hB9;
  localparam logic [7:0] WAKE_OPCODE_DEFAULT = 8'hAB;
  // Legacy signature value is arbitrary.
  localparam logic [7:0] LEGACY_SIG_DEFAULT = 8'h5A;

  // ****************************************************************
  // Power mode states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_ENTERING = 4'h2,
    ST_ASLEEP = 4'h4,
    ST_WAKING = 4'h8
  } sfpm_state_t;

endpackage : sfpm_pkg

`default_nettype wire

//--- core/sfpm_power_ctrl.sv
// Power-mode controller: deep sleep entry, wake with legacy signature, power-on write inhibit.
//
// Overview of operation
// - Deep sleep only via sleep instruction; asleep, all write/program/erase instructions ignored.
// - Deselect drops to standby when idle; deselect alone never enters deep sleep.
// - Power loss ends deep sleep; power-on always comes up in standby.
// - Sleep instruction executes only if deselect follows exactly eight bits.
// - After a valid sleep instruction, wait the entry delay before deep sleep.
// - Sleep instruction during an internal cycle is rejected, cycle undisturbed.
// - Wake instruction also returns the legacy eight-bit signature on serial output.
// - Outside internal cycles and mode transitions, wake returns the signature, asleep or in standby.
// - Wake instruction during an internal cycle is not decoded and has no effect.
// - Three dummy bytes follow wake opcode; signature shifts out on falling edges.
// - Further clocks with select low repeat the signature.
// - Deselect after a full signature: standby, immediate or after the full wake delay.
// - Deselect before first signature completes: standby, after the early wake delay if asleep.
// - While power-on reset holds, all logic reset and no instruction answered.
// - After reset, write-type instructions ignored until the power-up write inhibit elapses.
// - Power-up leaves standby with write latch and busy flag cleared.
`default_nettype none

module sfpm_power_ctrl #(
  parameter logic [7:0] SLEEP_OPCODE = sfpm_pkg::SLEEP_OPCODE_DEFAULT,
  parameter logic [7:0] WAKE_OPCODE = sfpm_pkg::WAKE_OPCODE_DEFAULT,
  parameter logic [7:0] LEGACY_SIG = sfpm_pkg::LEGACY_SIG_DEFAULT,
  parameter int SLEEP_ENTRY_CYCLES = sfpm_pkg::SLEEP_ENTRY_CYCLES,
  parameter int EARLY_WAKE_CYCLES = sfpm_pkg::EARLY_WAKE_CYCLES,
  parameter int FULL_WAKE_CYCLES = sfpm_pkg::FULL_WAKE_CYCLES,
  parameter int POWERUP_INHIBIT_CYCLES = sfpm_pkg::POWERUP_INHIBIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic internal_cycle_busy,
  output logic so_out,
  output logic so_oe,
  output logic deep_sleep,
  output logic standby,
  output logic instr_enable,
  output logic write_inhibit
);

  localparam int DLY_MAX = (FULL_WAKE_CYCLES > EARLY_WAKE_CYCLES) ?
    ((FULL_WAKE_CYCLES > SLEEP_ENTRY_CYCLES) ? FULL_WAKE_CYCLES : SLEEP_ENTRY_CYCLES) :
    ((EARLY_WAKE_CYCLES > SLEEP_ENTRY_CYCLES) ? EARLY_WAKE_CYCLES : SLEEP_ENTRY_CYCLES);
  localparam int DW = $clog2(DLY_MAX + 1);
  localparam int PW = $clog2(POWERUP_INHIBIT_CYCLES + 1);
  localparam logic [DW-1:0] SLEEP_LOAD = DW'(SLEEP_ENTRY_CYCLES - 1);
  localparam logic [DW-1:0] EARLY_LOAD = DW'(EARLY_WAKE_CYCLES - 1);
  localparam logic [DW-1:0] FULL_LOAD = DW'(FULL_WAKE_CYCLES - 1);
  localparam logic [PW-1:0] PUW_LOAD = PW'(POWERUP_INHIBIT_CYCLES);

  // ****************************************************************
  // State layouts
  // ****************************************************************
  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] shift;
    logic len8;
    logic op_sleep;
    logic wake_act;
    logic sig_seen;
    logic frame_tog;
    logic busy_s1;
    logic busy_s2;
    logic ready_s1;
    logic ready_s2;
  } sfpm_rise_t;

  typedef struct packed {
    logic so_out;
    logic so_oe;
  } sfpm_fall_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic cs_s4;
    logic [4:0] flag_s1;
    logic [4:0] flag_s2;
    logic tog_seen;
    sfpm_pkg::sfpm_state_t state;
    logic [DW-1:0] dly;
    logic [PW-1:0] puw;
    logic ready;
    logic deep_sleep;
    logic standby;
    logic instr_enable;
    logic write_inhibit;
  } sfpm_ref_t;

  sfpm_rise_t rise_reg;
  sfpm_rise_t rise_next;
  sfpm_fall_t fall_reg;
  sfpm_fall_t fall_next;
  sfpm_ref_t ref_reg;
  sfpm_ref_t ref_next;
  logic in_frame_reg;
  logic link_rst_n;

  // The frame flag and the output stage are cleared by deselect as well as by power-on reset; the frame's own
  // select line ends it, because the serial clock stands still between frames.
  assign link_rst_n = arst_n & ~cs_n;

  // ****************************************************************
  // Link side, rising serial clock: opcode capture and bit counting
  // ****************************************************************
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  always_comb begin
    logic first;
    logic [7:0] cur;
    logic [5:0] base;
    first = ~in_frame_reg;
    cur = first ? {7'h00, si} : {rise_reg.shift[6:0], si};
    base = first ? 6'h00 : rise_reg.cnt;
    rise_next = rise_reg;
    rise_next.busy_s1 = internal_cycle_busy;
    rise_next.busy_s2 = rise_reg.busy_s1;
    rise_next.ready_s1 = ref_reg.ready;
    rise_next.ready_s2 = rise_reg.ready_s1;
    if (first) begin
      // Results of the previous frame are kept until now so the reference side can read them.
      rise_next.frame_tog = ~rise_reg.frame_tog;
      rise_next.op_sleep = 1'b0;
      rise_next.wake_act = 1'b0;
      rise_next.sig_seen = 1'b0;
    end
    rise_next.shift = cur;
    rise_next.cnt = (base == sfpm_pkg::SIG_LAST_CNT) ? sfpm_pkg::SIG_FIRST_CNT : base + 6'h01;
    rise_next.len8 = (rise_next.cnt == sfpm_pkg::OPCODE_BITS);
    if (base == sfpm_pkg::OPCODE_LAST_BIT) begin
      rise_next.op_sleep = (cur == SLEEP_OPCODE);
      // A wake opcode is not decoded during an internal cycle or a mode transition.
      rise_next.wake_act = (cur == WAKE_OPCODE) && !rise_reg.busy_s2 && rise_reg.ready_s2;
    end
    if ((base == sfpm_pkg::SIG_LAST_CNT) && rise_reg.wake_act) begin
      rise_next.sig_seen = 1'b1;
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      rise_reg <= '0;
    end else begin
      rise_reg <= rise_next;
    end
  end

  // ****************************************************************
  // Link side, falling serial clock: signature output
  // ****************************************************************
  always_comb begin
    fall_next.so_oe = 1'b0;
    fall_next.so_out = 1'b0;
    if (rise_reg.wake_act && (rise_reg.cnt >= sfpm_pkg::SIG_FIRST_CNT)) begin
      fall_next.so_oe = 1'b1;
      fall_next.so_out = LEGACY_SIG[3'h7 - rise_reg.cnt[2:0]];
    end
  end

  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= fall_next;
    end
  end

  // ****************************************************************
  // Reference side: frame end handling and power-mode sequencing
  // ****************************************************************
  always_comb begin
    logic frame_end;
    logic fr_new;
    logic f_len8;
    logic f_sleep;
    logic f_wake;
    logic f_sig;
    ref_next = ref_reg;
    ref_next.cs_s1 = cs_n;
    ref_next.cs_s2 = ref_reg.cs_s1;
    ref_next.cs_s3 = ref_reg.cs_s2;
    ref_next.cs_s4 = ref_reg.cs_s3;
    ref_next.flag_s1 = {rise_reg.frame_tog, rise_reg.sig_seen, rise_reg.wake_act, rise_reg.op_sleep, rise_reg.len8};
    ref_next.flag_s2 = ref_reg.flag_s1;
    // The select edge is delayed one stage past the flags so the frame results have settled.
    frame_end = ref_reg.cs_s3 & ~ref_reg.cs_s4;
    fr_new = ref_reg.flag_s2[4] ^ ref_reg.tog_seen;
    f_len8 = ref_reg.flag_s2[0];
    f_sleep = ref_reg.flag_s2[1];
    f_wake = ref_reg.flag_s2[2];
    f_sig = ref_reg.flag_s2[3];
    if (frame_end) begin
      ref_next.tog_seen = ref_reg.flag_s2[4];
    end
    if (ref_reg.puw != '0) begin
      ref_next.puw = ref_reg.puw - PW'(1);
    end
    case (ref_reg.state)
      sfpm_pkg::ST_STANDBY: begin
        // Deselect alone leaves the block in standby; only an exact sleep frame moves on.
        if (frame_end && fr_new && f_len8 && f_sleep && !internal_cycle_busy) begin
          ref_next.state = sfpm_pkg::ST_ENTERING;
          ref_next.dly = SLEEP_LOAD;
        end
      end
      sfpm_pkg::ST_ENTERING: begin
        if (ref_reg.dly == '0) begin
          ref_next.state = sfpm_pkg::ST_ASLEEP;
        end else begin
          ref_next.dly = ref_reg.dly - DW'(1);
        end
      end
      sfpm_pkg::ST_ASLEEP: begin
        if (frame_end && fr_new && f_wake) begin
          ref_next.state = sfpm_pkg::ST_WAKING;
          ref_next.dly = f_sig ? FULL_LOAD : EARLY_LOAD;
        end
      end
      sfpm_pkg::ST_WAKING: begin
        if (ref_reg.dly == '0) begin
          ref_next.state = sfpm_pkg::ST_STANDBY;
        end else begin
          ref_next.dly = ref_reg.dly - DW'(1);
        end
      end
      default: begin
        ref_next.state = sfpm_pkg::ST_STANDBY;
        ref_next.dly = '0;
      end
    endcase
    // A wake seen in standby needs no delay, so nothing changes there.
    ref_next.ready = (ref_next.state == sfpm_pkg::ST_STANDBY) || (ref_next.state == sfpm_pkg::ST_ASLEEP);
    ref_next.deep_sleep = (ref_next.state == sfpm_pkg::ST_ASLEEP);
    ref_next.standby = (ref_next.state == sfpm_pkg::ST_STANDBY);
    ref_next.instr_enable = (ref_next.state == sfpm_pkg::ST_STANDBY);
    ref_next.write_inhibit = (ref_next.puw != '0) || (ref_next.state != sfpm_pkg::ST_STANDBY);
  end

  // Power-on reset clears the mode outputs but raises write inhibit; the block always starts in standby with the write
  // inhibit counter loaded, so a supply dip also ends deep sleep.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_reg.cs_s1 <= 1'b1;
      ref_reg.cs_s2 <= 1'b1;
      ref_reg.cs_s3 <= 1'b1;
      ref_reg.cs_s4 <= 1'b1;
      ref_reg.flag_s1 <= '0;
      ref_reg.flag_s2 <= '0;
      ref_reg.tog_seen <= 1'b0;
      ref_reg.state <= sfpm_pkg::ST_STANDBY;
      ref_reg.dly <= '0;
      ref_reg.puw <= PUW_LOAD;
      ref_reg.ready <= 1'b0;
      ref_reg.deep_sleep <= 1'b0;
      ref_reg.standby <= 1'b0;
      ref_reg.instr_enable <= 1'b0;
      ref_reg.write_inhibit <= 1'b1;
    end else begin
      ref_reg <= ref_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign so_out = fall_reg.so_out;
  assign so_oe = fall_reg.so_oe;
  assign deep_sleep = ref_reg.deep_sleep;
  assign standby = ref_reg.standby;
  assign instr_enable = ref_reg.instr_enable;
  assign write_inhibit = ref_reg.write_inhibit;

endmodule : sfpm_power_ctrl

`default_nettype wire

//--- tb/sfpm_power_ctrl_props.sv
// Concurrent checks on the ports of the power-mode controller.
`default_nettype none

module sfpm_power_ctrl_props #(
  parameter int POWERUP_INHIBIT_CYCLES = 50
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic internal_cycle_busy,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic deep_sleep,
  input wire logic standby,
  input wire logic instr_enable,
  input wire logic write_inhibit
);
  // ****************************************************************
  // Cycles since reset release
  // ****************************************************************
  int up_cnt;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_cnt <= 0;
    end else if (up_cnt < POWERUP_INHIBIT_CYCLES + 2) begin
      up_cnt <= up_cnt + 1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  property p_one_mode;
    !(deep_sleep && standby);
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("sleep and standby together");
  property p_instr;
    instr_enable == standby;
  endproperty
  a_instr: assert property (p_instr) else $error("instruction enable differs from standby");
  property p_powerup;
    !$past(arst_n) |=> standby && !deep_sleep;
  endproperty
  a_powerup: assert property (p_powerup) else $error("not standby after reset");
  property p_inhibit_hold;
    up_cnt < POWERUP_INHIBIT_CYCLES || !standby |-> write_inhibit;
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("write inhibit dropped early");
  property p_inhibit_end;
    up_cnt == POWERUP_INHIBIT_CYCLES + 2 && standby |-> !write_inhibit;
  endproperty
  a_inhibit_end: assert property (p_inhibit_end) else $error("write inhibit stuck");
  property p_entry;
    $fell(standby) |-> !deep_sleep [*4] ##[1:8] deep_sleep;
  endproperty
  a_entry: assert property (p_entry) else $error("sleep entry delay wrong");
  property p_busy_guard;
    $fell(standby) |-> !$past(internal_cycle_busy);
  endproperty
  a_busy_guard: assert property (p_busy_guard) else $error("sleep accepted while busy");
  property p_wake;
    $fell(deep_sleep) |-> !standby [*4] ##[1:12] standby;
  endproperty
  a_wake: assert property (p_wake) else $error("wake delay wrong");
  property p_oe_sel;
    so_oe |-> !cs_n;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output driven while deselected");
  property p_so_idle;
    !so_oe |-> !so_out;
  endproperty
  a_so_idle: assert property (p_so_idle) else $error("serial output not idle");
endmodule : sfpm_power_ctrl_props

bind sfpm_power_ctrl sfpm_power_ctrl_props #(.POWERUP_INHIBIT_CYCLES(POWERUP_INHIBIT_CYCLES)) u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .internal_cycle_busy(internal_cycle_busy),
  .so_out(so_out), .so_oe(so_oe), .deep_sleep(deep_sleep), .standby(standby),
  .instr_enable(instr_enable), .write_inhibit(write_inhibit));

`default_nettype wire

//--- tb/sfpm_spi_host.sv
// Host model that frames serial instructions towards the controller.
`default_nettype none

module sfpm_spi_host (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The link clock stands low between frames, so nothing is clocked while deselected.
  // Select is unknown for the first nanosecond so that the link logic sees its reset as an edge.
  initial begin
    sclk = 1'b0;
    si = 1'b0;
    #1 cs_n = 1'b1;
  end

  task automatic xfer(input logic [47:0] bits, input int n, output logic [7:0] sig);
    sig = 8'h00;
    // This offset keeps every select edge clear of the reference clock edges that the bench waits on.
    #2 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = bits[47-i];
      #16 sclk = 1'b1;
      if (i >= 32) sig = {sig[6:0], so_out};
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    si = ~si; // Released data must not repeat the last bit.
  endtask : xfer
endmodule : sfpm_spi_host

`default_nettype wire

//--- tb/tb_spi_flash_power_mode_ctrl.sv
// Self-checking bench for the serial flash power-mode controller.
`default_nettype none

module tb_spi_flash_power_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ENTRY = 6;
  localparam int EARLY = 5;
  localparam int FULL = 9;
  localparam int INHIBIT = 50;
  localparam logic [7:0] SLEEP = sfpm_pkg::SLEEP_OPCODE_DEFAULT;
  localparam logic [7:0] WAKE = sfpm_pkg::WAKE_OPCODE_DEFAULT;
  // Signature value is arbitrary.
  localparam logic [7:0] SIG = 8'hC3;
  // Reset falls after time zero, before the first rising clock edge, so it arrives as a real edge.
  logic ref_clk = 1'b1;
  logic arst_n = 1'b1;
  logic busy = 1'b0;
  wire logic sclk, cs_n, si, so_out, so_oe, deep_sleep, standby, instr_en, wr_inh;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] sig;

  always #12.5 ref_clk = ~ref_clk;

  sfpm_power_ctrl #(.LEGACY_SIG(SIG), .SLEEP_ENTRY_CYCLES(ENTRY), .EARLY_WAKE_CYCLES(EARLY),
    .FULL_WAKE_CYCLES(FULL), .POWERUP_INHIBIT_CYCLES(INHIBIT)) u_dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .internal_cycle_busy(busy),
    .so_out(so_out), .so_oe(so_oe), .deep_sleep(deep_sleep), .standby(standby),
    .instr_enable(instr_en), .write_inhibit(wr_inh));
  sfpm_spi_host u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Mode bits: sleep, standby, instruction enable, write inhibit.
  function automatic logic [7:0] mode();
    return {4'h0, deep_sleep, standby, instr_en, wr_inh};
  endfunction : mode

  task automatic cyc_wait(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc_wait

  // The gap after each frame covers the deselect synchroniser and edge detect.
  task automatic frame(input logic [7:0] op, input int n);
    u_host.xfer({op, 40'h0}, n, sig);
    cyc_wait(8);
  endtask : frame

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_power_up();
    cyc_wait(1);
    arst_n = 1'b0;
    cyc_wait(6);
    chk("reset_mode", 8'h01, mode());
    chk("reset_oe", 8'h00, {7'h0, so_oe});
    arst_n = 1'b1;
    cyc_wait(2);
    chk("powerup_mode", 8'h07, mode());
    cyc_wait(INHIBIT - 6);
    chk("inhibit_held", 8'h07, mode());
    cyc_wait(6);
    chk("inhibit_over", 8'h06, mode());
    cyc_wait(sfpm_pkg::POWERUP_SELECT_DELAY_US * 1000 / sfpm_pkg::REF_PERIOD_NS);
  endtask : t_power_up

  task automatic t_sig_standby();
    frame(WAKE, 48);
    chk("sig_repeat", SIG, sig);
    frame(WAKE, 40);
    chk("sig_first", SIG, sig);
    chk("wake_no_sleep", 8'h06, mode());
    frame(WAKE, 16);
    cyc_wait(1);
    chk("early_no_sleep", 8'h06, mode());
  endtask : t_sig_standby

  task automatic t_bad_sleep();
    frame(SLEEP, 9);
    frame(SLEEP, 7);
    cyc_wait(ENTRY + 4);
    chk("sleep_bad_len", 8'h06, mode());
  endtask : t_bad_sleep

  task automatic t_busy();
    busy = 1'b1;
    frame(SLEEP, 8);
    cyc_wait(ENTRY + 4);
    chk("sleep_busy", 8'h06, mode());
    frame(WAKE, 40);
    chk("wake_busy_sig", 8'h00, sig);
    busy = 1'b0;
    cyc_wait(2);
  endtask : t_busy

  task automatic t_sleep_wake_full();
    frame(SLEEP, 8);
    chk("entering", 8'h01, mode());
    cyc_wait(ENTRY + 4);
    chk("asleep", 8'h09, mode());
    frame(WAKE, 40);
    chk("sig_asleep", SIG, sig);
    cyc_wait(5);
    chk("full_waking", 8'h01, mode());
    cyc_wait(FULL);
    chk("full_awake", 8'h06, mode());
  endtask : t_sleep_wake_full

  task automatic t_wake_early();
    frame(SLEEP, 8);
    cyc_wait(ENTRY + 4);
    frame(WAKE, 16);
    chk("early_waking", 8'h01, mode());
    // The next look falls between the end of the early delay and the end of the full one.
    cyc_wait(2);
    chk("early_awake", 8'h06, mode());
  endtask : t_wake_early

  task automatic t_reset_mid();
    frame(SLEEP, 8);
    cyc_wait(ENTRY + 4);
    arst_n = 1'b0;
    cyc_wait(2);
    chk("mid_reset", 8'h01, mode());
    arst_n = 1'b1;
    cyc_wait(2);
    chk("mid_powerup", 8'h07, mode());
  endtask : t_reset_mid

  initial begin
    t_power_up();
    t_sig_standby();
    t_bad_sleep();
    t_busy();
    t_sleep_wake_full();
    t_wake_early();
    t_reset_mid();
    print_verdict();
  end

  // A hang is cut short well beyond the fewer than two thousand cycles the run needs.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      print_verdict();
    end
  end
endmodule : tb_spi_flash_power_mode_ctrl

`default_nettype wire
